// ### pin_mux_pkg.sv
`default_nettype none
package pin_mux_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus shape
  localparam int PADDR_W   = 8;
  localparam int PDATA_W   = 32;
  localparam int PSTRB_W   = 4;
  localparam int REG_W     = 8;
  localparam int PORT_A_W  = 8;
  localparam int PORT_C_W  = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [PADDR_W-1:0] ADDR_SYS_CONFIG    = 8'h00;
  localparam logic [PADDR_W-1:0] ADDR_INT_EDGE_PIN  = 8'h04;
  localparam logic [PADDR_W-1:0] ADDR_PORT_C_DATA   = 8'h08;
  localparam logic [PADDR_W-1:0] ADDR_PORT_C_DIR    = 8'h0C;
  localparam logic [PADDR_W-1:0] ADDR_PORT_C_LEVELS = 8'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int SYS_HOST_BIT     = 1;
  localparam int SYS_CHAN_B_BIT   = 2;
  localparam int SYS_PORT_B_BIT   = 5;
  localparam int SYS_PORT_C_BIT   = 7;
  localparam int IEP_DAISY_BIT    = 2;
  localparam int IEP_STROBE_BIT   = 3;
  localparam int PC_CARRIER       = 0;
  localparam int PC_CLEAR_TO_SEND = 1;
  localparam int PC_WRITE_RTS     = 2;
  localparam int PC_TERM_READY    = 3;
  localparam int PC_SYNC          = 4;
  localparam int PC_WAIT_REQ      = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [REG_W-1:0]    SYS_CONFIG_RESET   = 8'h00;
  localparam logic [REG_W-1:0]    INT_EDGE_PIN_RESET = 8'h00;
  localparam logic [PORT_C_W-1:0] PORT_C_DATA_RESET  = 6'h00;
  localparam logic [PORT_C_W-1:0] PORT_C_DIR_RESET   = 6'h00;

  typedef enum logic [1:0] {FUNC_PRIMARY, FUNC_SECONDARY, FUNC_TERTIARY} pin_func_e;

endpackage : pin_mux_pkg
`default_nettype wire

// ### pin_function_mux.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Config bits one, two pick pin tier
// - Config bit seven swaps channel A, port C
// - Edge/pin bit three picks read or request strobe
// - Write strobe pin uses bit seven and bit three
// - Port C six, seven read irq pins only
// - Edge/pin bit two enables daisy chain out
// - Config bit five holds clear-to-send low
module pin_function_mux (
  input  wire logic                                clk,
  input  wire logic                                rst,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [pin_mux_pkg::PADDR_W-1:0]     paddr,
  input  wire logic [pin_mux_pkg::PDATA_W-1:0]     pwdata,
  input  wire logic [pin_mux_pkg::PSTRB_W-1:0]     pstrb,
  output logic      [pin_mux_pkg::PDATA_W-1:0]     prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic                                pinClkEndIn,
  output logic                                     pinClkEndOut,
  output logic                                     pinClkEndOe,
  input  wire logic                                serialClock1OrDma0EndOut,
  input  wire logic                                serialClock1OrDma0EndOe,
  output logic                                     serialClock1OrDma0EndIn,
  input  wire logic                                chanBTerminalReadyOrRequestN,
  input  wire logic                                hostInterruptOut,
  input  wire logic                                pinReqIn,
  output logic                                     pinReqOut,
  output logic                                     pinReqOe,
  output logic                                     dma1RequestN,
  input  wire logic                                chanBWaitOrRequestN,
  input  wire logic                                hostTransmitReadyN,
  output logic                                     pinEndRtsOut,
  input  wire logic                                dma1EndN,
  input  wire logic                                chanBRequestToSendN,
  input  wire logic                                hostReceiveReadyN,
  input  wire logic [pin_mux_pkg::PORT_A_W-1:0]    pinPortAIn,
  output logic      [pin_mux_pkg::PORT_A_W-1:0]    pinPortAOut,
  output logic      [pin_mux_pkg::PORT_A_W-1:0]    pinPortAOe,
  input  wire logic [pin_mux_pkg::PORT_A_W-1:0]    portABitsOut,
  input  wire logic [pin_mux_pkg::PORT_A_W-1:0]    portABitsOe,
  output logic      [pin_mux_pkg::PORT_A_W-1:0]    portABitsIn,
  input  wire logic [pin_mux_pkg::PORT_A_W-1:0]    hostDataBusOut,
  input  wire logic                                hostDataBusOe,
  output logic      [pin_mux_pkg::PORT_A_W-1:0]    hostDataBusIn,
  input  wire logic [pin_mux_pkg::PORT_C_W-1:0]    pinPortCIn,
  output logic      [pin_mux_pkg::PORT_C_W-1:0]    pinPortCOut,
  output logic      [pin_mux_pkg::PORT_C_W-1:0]    pinPortCOe,
  input  wire logic                                chanAWaitOrRequestN,
  input  wire logic                                chanATerminalReadyOrRequestN,
  input  wire logic                                chanARequestToSendN,
  output logic                                     chanAClearToSendN,
  output logic                                     chanACarrierDetectN,
  input  wire logic                                chanASyncOut,
  input  wire logic                                chanASyncOe,
  output logic                                     chanASyncIn,
  input  wire logic                                cpuMemRequestN,
  input  wire logic                                cpuReadN,
  input  wire logic                                cpuWriteN,
  input  wire logic                                cpuBusDriveEn,
  output logic                                     pinMemStrobeOut,
  output logic                                     pinMemStrobeOe,
  input  wire logic                                ioChipSelectN,
  input  wire logic                                daisyChainEnableOut,
  output logic                                     pinChipSelOut,
  input  wire logic                                externalIrq1N,
  input  wire logic                                externalIrq2N,
  input  wire logic                                pinCts0In,
  output logic                                     async0ClearToSendN,
  output logic                                     portBBit1In
);
  import pin_mux_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Tier decode

  function automatic pin_func_e tierOf(input logic [REG_W-1:0] cfg);
    if (cfg[SYS_HOST_BIT]) begin
      tierOf = FUNC_TERTIARY;
    end else if (cfg[SYS_CHAN_B_BIT]) begin
      tierOf = FUNC_SECONDARY;
    end else begin
      tierOf = FUNC_PRIMARY;
    end
  endfunction : tierOf

  //////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [REG_W-1:0]    sysCfgReg,    sysCfgNext;
  logic [REG_W-1:0]    intEdgeReg,   intEdgeNext;
  logic [PORT_C_W-1:0] portCDataReg, portCDataNext;
  logic [PORT_C_W-1:0] portCDirReg,  portCDirNext;
  logic [PDATA_W-1:0]  prdataReg,    prdataNext;
  logic                pslverrReg,   pslverrNext;
  logic [REG_W-1:0]    portCLevels;
  logic                setupPhase;
  logic                writeTaken;
  pin_func_e           tier;

  assign setupPhase  = psel && !penable;
  assign writeTaken  = psel && penable && pwrite && pstrb[0];
  assign portCLevels = {externalIrq2N, externalIrq1N, pinPortCIn};
  assign tier        = tierOf(sysCfgReg);

  always_comb begin
    sysCfgNext    = sysCfgReg;
    intEdgeNext   = intEdgeReg;
    portCDataNext = portCDataReg;
    portCDirNext  = portCDirReg;
    prdataNext    = prdataReg;
    pslverrNext   = pslverrReg;
    if (setupPhase) begin
      pslverrNext = 1'b0;
      case (paddr)
        ADDR_SYS_CONFIG:    prdataNext = {24'h000000, sysCfgReg};
        ADDR_INT_EDGE_PIN:  prdataNext = {24'h000000, intEdgeReg};
        ADDR_PORT_C_DATA:   prdataNext = {26'h0000000, portCDataReg};
        ADDR_PORT_C_DIR:    prdataNext = {26'h0000000, portCDirReg};
        ADDR_PORT_C_LEVELS: prdataNext = {24'h000000, portCLevels};
        default: begin
          prdataNext  = 32'h00000000;
          pslverrNext = 1'b1;
        end
      endcase
    end
    if (writeTaken) begin
      case (paddr)
        ADDR_SYS_CONFIG:   sysCfgNext    = pwdata[REG_W-1:0];
        ADDR_INT_EDGE_PIN: intEdgeNext   = pwdata[REG_W-1:0];
        ADDR_PORT_C_DATA:  portCDataNext = pwdata[PORT_C_W-1:0];
        ADDR_PORT_C_DIR:   portCDirNext  = pwdata[PORT_C_W-1:0];
        default: begin
          sysCfgNext = sysCfgReg;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sysCfgReg    <= SYS_CONFIG_RESET;
      intEdgeReg   <= INT_EDGE_PIN_RESET;
      portCDataReg <= PORT_C_DATA_RESET;
      portCDirReg  <= PORT_C_DIR_RESET;
      prdataReg    <= 32'h00000000;
      pslverrReg   <= 1'b0;
    end else begin
      sysCfgReg    <= sysCfgNext;
      intEdgeReg   <= intEdgeNext;
      portCDataReg <= portCDataNext;
      portCDirReg  <= portCDirNext;
      prdataReg    <= prdataNext;
      pslverrReg   <= pslverrNext;
    end
  end

  assign prdata  = prdataReg;
  assign pslverr = pslverrReg;
  assign pready  = 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // Pin routing

  always_comb begin
    pinClkEndOut            = serialClock1OrDma0EndOut;
    pinClkEndOe             = serialClock1OrDma0EndOe;
    serialClock1OrDma0EndIn = 1'b1;
    pinReqOut               = 1'b1;
    pinReqOe                = 1'b0;
    dma1RequestN            = 1'b1;
    pinEndRtsOut            = dma1EndN;
    case (tier)
      FUNC_PRIMARY: begin
        serialClock1OrDma0EndIn = pinClkEndIn;
        dma1RequestN            = pinReqIn;
      end
      FUNC_SECONDARY: begin
        pinClkEndOut = chanBTerminalReadyOrRequestN;
        pinClkEndOe  = 1'b1;
        pinReqOut    = chanBWaitOrRequestN;
        pinReqOe     = 1'b1;
        pinEndRtsOut = chanBRequestToSendN;
      end
      FUNC_TERTIARY: begin
        pinClkEndOut = hostInterruptOut;
        pinClkEndOe  = 1'b1;
        pinReqOut    = hostTransmitReadyN;
        pinReqOe     = 1'b1;
        pinEndRtsOut = hostReceiveReadyN;
      end
      default: begin
        pinClkEndOe = 1'b0;
      end
    endcase
  end

  always_comb begin
    if (sysCfgReg[SYS_HOST_BIT]) begin
      pinPortAOut   = hostDataBusOut;
      pinPortAOe    = {PORT_A_W{hostDataBusOe}};
      hostDataBusIn = pinPortAIn;
      portABitsIn   = 8'hFF;
    end else begin
      pinPortAOut   = portABitsOut;
      pinPortAOe    = portABitsOe;
      hostDataBusIn = 8'hFF;
      portABitsIn   = pinPortAIn;
    end
  end

  always_comb begin
    pinPortCOut         = portCDataReg;
    pinPortCOe          = portCDirReg;
    chanAClearToSendN   = 1'b1;
    chanACarrierDetectN = 1'b1;
    chanASyncIn         = 1'b1;
    if (!sysCfgReg[SYS_PORT_C_BIT]) begin
      pinPortCOut[PC_WAIT_REQ]   = chanAWaitOrRequestN;
      pinPortCOe[PC_WAIT_REQ]    = 1'b1;
      pinPortCOut[PC_TERM_READY] = chanATerminalReadyOrRequestN;
      pinPortCOe[PC_TERM_READY]  = 1'b1;
      pinPortCOut[PC_SYNC]       = chanASyncOut;
      pinPortCOe[PC_SYNC]        = chanASyncOe;
      pinPortCOut[PC_CLEAR_TO_SEND] = 1'b1;
      pinPortCOe[PC_CLEAR_TO_SEND]  = 1'b0;
      pinPortCOut[PC_CARRIER]    = 1'b1;
      pinPortCOe[PC_CARRIER]     = 1'b0;
      pinPortCOut[PC_WRITE_RTS]  = chanARequestToSendN;
      pinPortCOe[PC_WRITE_RTS]   = 1'b1;
      chanAClearToSendN          = pinPortCIn[PC_CLEAR_TO_SEND];
      chanACarrierDetectN        = pinPortCIn[PC_CARRIER];
      chanASyncIn                = pinPortCIn[PC_SYNC];
    end
    if (!intEdgeReg[IEP_STROBE_BIT]) begin
      pinPortCOut[PC_WRITE_RTS] = cpuMemRequestN | cpuWriteN;
      pinPortCOe[PC_WRITE_RTS]  = cpuBusDriveEn;
    end
  end

  always_comb begin
    pinMemStrobeOe = cpuBusDriveEn;
    if (intEdgeReg[IEP_STROBE_BIT]) begin
      pinMemStrobeOut = cpuMemRequestN;
    end else begin
      pinMemStrobeOut = cpuMemRequestN | cpuReadN;
    end
    pinChipSelOut = intEdgeReg[IEP_DAISY_BIT] ? daisyChainEnableOut : ioChipSelectN;
    if (sysCfgReg[SYS_PORT_B_BIT]) begin
      async0ClearToSendN = 1'b0;
      portBBit1In        = pinCts0In;
    end else begin
      async0ClearToSendN = pinCts0In;
      portBBit1In        = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_hostTier;
    @(posedge clk) disable iff (rst)
      (tier == FUNC_TERTIARY) |->
        (pinClkEndOut == hostInterruptOut) && (pinReqOut == hostTransmitReadyN) &&
        (pinEndRtsOut == hostReceiveReadyN) && (dma1RequestN == 1'b1);
  endproperty
  a_hostTier: assert property (p_hostTier) else $error("Host tier not routed");

  property p_chanBTier;
    @(posedge clk) disable iff (rst)
      (writeTaken && paddr == ADDR_SYS_CONFIG && pwdata[2:1] == 2'b10) |=>
        (pinClkEndOut == chanBTerminalReadyOrRequestN) && pinReqOe &&
        (pinEndRtsOut == chanBRequestToSendN);
  endproperty
  a_chanBTier: assert property (p_chanBTier) else $error("Channel B tier not routed");

  property p_portCMode;
    @(posedge clk) disable iff (rst)
      sysCfgReg[SYS_PORT_C_BIT] |->
        (pinPortCOe[PC_WAIT_REQ] == portCDirReg[PC_WAIT_REQ]) &&
        (pinPortCOut[PC_SYNC] == portCDataReg[PC_SYNC]) && chanACarrierDetectN;
  endproperty
  a_portCMode: assert property (p_portCMode) else $error("Port C mode not routed");

  property p_strobeSel;
    @(posedge clk) disable iff (rst)
      (writeTaken && paddr == ADDR_INT_EDGE_PIN) |=>
        (pinMemStrobeOut == ($past(pwdata[3]) ? cpuMemRequestN : (cpuMemRequestN | cpuReadN)));
  endproperty
  a_strobeSel: assert property (p_strobeSel) else $error("Memory strobe mismatch");

  property p_writePin;
    @(posedge clk) disable iff (rst)
      !intEdgeReg[IEP_STROBE_BIT] |->
        (pinPortCOut[PC_WRITE_RTS] == (cpuMemRequestN | cpuWriteN)) &&
        (pinPortCOe[PC_WRITE_RTS] == cpuBusDriveEn);
  endproperty
  a_writePin: assert property (p_writePin) else $error("Write strobe pin mismatch");

  property p_irqLevels;
    @(posedge clk) disable iff (rst)
      (setupPhase && !pwrite && paddr == ADDR_PORT_C_LEVELS) |=>
        (prdata[7:6] == {$past(externalIrq2N), $past(externalIrq1N)});
  endproperty
  a_irqLevels: assert property (p_irqLevels) else $error("Irq levels not read");

  property p_daisy;
    @(posedge clk) disable iff (rst)
      intEdgeReg[IEP_DAISY_BIT] |-> (pinChipSelOut == daisyChainEnableOut);
  endproperty
  a_daisy: assert property (p_daisy) else $error("Daisy chain output missing");

  property p_ctsHeld;
    @(posedge clk) disable iff (rst)
      sysCfgReg[SYS_PORT_B_BIT] |-> !async0ClearToSendN && (portBBit1In == pinCts0In);
  endproperty
  a_ctsHeld: assert property (p_ctsHeld) else $error("Clear-to-send not held low");

  property p_idleInputs;
    @(posedge clk) disable iff (rst)
      (tier == FUNC_PRIMARY) |->
        (hostDataBusIn == 8'hFF) && (pinPortAOe == portABitsOe) && (dma1RequestN == pinReqIn);
  endproperty
  a_idleInputs: assert property (p_idleInputs) else $error("Unselected input active");

endmodule : pin_function_mux
`default_nettype wire

// ### pin_side_model.sv
`timescale 1ns/1ns
`default_nettype none
module pin_side_model (
  input  wire logic [7:0]  pat,
  output logic      [31:0] drive
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin and peripheral levels; alternate bytes inverted so neighbours differ
  assign drive = {~pat, pat, ~pat, pat};
endmodule : pin_side_model
`default_nettype wire

// ### pin_function_mux_test.sv
`timescale 1ns/1ns
`default_nettype none
module pin_function_mux_test;
  import pin_mux_pkg::*;
  logic                clk;
  logic                rst;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [PADDR_W-1:0]  paddr;
  logic [PDATA_W-1:0]  pwdata;
  logic [PSTRB_W-1:0]  pstrb;
  logic [PDATA_W-1:0]  prdata;
  logic                pready;
  logic                pslverr;
  logic [7:0]          pat;
  wire logic [31:0]    w;
  logic                pinClkEndOut, serialClock1OrDma0EndIn, pinReqOut, dma1RequestN;
  logic                pinEndRtsOut, chanAClearToSendN, chanACarrierDetectN, pinChipSelOut;
  logic                pinMemStrobeOut, pinMemStrobeOe, async0ClearToSendN;
  logic                pinClkEndOe, pinReqOe, chanASyncIn, portBBit1In;
  logic [PORT_A_W-1:0] pinPortAOut, portABitsIn, hostDataBusIn, pinPortAOe;
  logic [PORT_C_W-1:0] pinPortCOut, pinPortCOe;
  int                  mismatches;
  int                  tests_run;
  logic [7:0]          cfgs [6] = '{8'h00, 8'h04, 8'h02, 8'h06, 8'hA0, 8'h80};
  logic [7:0]          ieps [4] = '{8'h00, 8'h04, 8'h08, 8'h0C};

  pin_side_model partner (.pat(pat), .drive(w));

  pin_function_mux DUT (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .pinClkEndIn(w[3]), .pinClkEndOut, .pinClkEndOe,
    .serialClock1OrDma0EndOut(w[0]), .serialClock1OrDma0EndOe(w[4]), .serialClock1OrDma0EndIn,
    .chanBTerminalReadyOrRequestN(w[1]), .hostInterruptOut(w[2]),
    .pinReqIn(w[5]), .pinReqOut, .pinReqOe, .dma1RequestN,
    .chanBWaitOrRequestN(w[6]), .hostTransmitReadyN(w[7]), .pinEndRtsOut,
    .dma1EndN(w[8]), .chanBRequestToSendN(w[9]), .hostReceiveReadyN(w[10]),
    .pinPortAIn(w[7:0]), .pinPortAOut, .pinPortAOe, .portABitsOut(w[15:8]),
    .portABitsOe(w[7:0]), .portABitsIn, .hostDataBusOut(w[23:16]), .hostDataBusOe(w[21]),
    .hostDataBusIn, .pinPortCIn(w[5:0]), .pinPortCOut, .pinPortCOe,
    .chanAWaitOrRequestN(w[22]), .chanATerminalReadyOrRequestN(w[23]),
    .chanARequestToSendN(w[14]), .chanAClearToSendN, .chanACarrierDetectN,
    .chanASyncOut(w[24]), .chanASyncOe(w[25]), .chanASyncIn,
    .cpuMemRequestN(w[11]), .cpuReadN(w[12]), .cpuWriteN(w[13]), .cpuBusDriveEn(w[15]),
    .pinMemStrobeOut, .pinMemStrobeOe, .ioChipSelectN(w[16]), .daisyChainEnableOut(w[17]),
    .pinChipSelOut, .externalIrq1N(w[18]), .externalIrq2N(w[19]), .pinCts0In(w[20]),
    .async0ClearToSendN, .portBBit1In
  );

  ////////////////////////////////////////////////////////////////////////////
  // Closing, comparison and bus tasks
  task wrap_up;
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= 4'hF;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task check_pins(input logic [7:0] cfg, input logic [7:0] iep);
    logic [7:0] pats [4];
    int         t;
    logic       m;
    pats = '{8'h55, 8'h33, 8'hAA, 8'hCC};
    t = cfg[1] ? 2 : (cfg[2] ? 1 : 0);
    foreach (pats[i]) begin
      @(posedge clk);
      pat <= pats[i];
      @(negedge clk);
      m = iep[3] | w[15];
      chk(pinClkEndOut, w[t]);
      chk(pinClkEndOe, t == 0 ? w[4] : 1'b1);
      chk(pinEndRtsOut, w[8 + t]);
      if (t != 0) chk(pinReqOut, w[5 + t]);
      chk(pinReqOe, t != 0);
      chk(pinPortAOut, t == 2 ? pat : 8'(~pat));
      chk(pinPortAOe, t == 2 ? {8{w[21]}} : pat);
      chk(serialClock1OrDma0EndIn, t == 0 ? w[3] : 1'b1);
      chk(dma1RequestN, t == 0 ? w[5] : 1'b1);
      chk(portABitsIn, t == 2 ? 8'hFF : pat);
      chk(hostDataBusIn, t == 2 ? pat : 8'hFF);
      chk(pinMemStrobeOut, iep[3] ? w[11] : (w[11] | w[12]));
      chk(pinMemStrobeOe, w[15]);
      chk(pinPortCOut[2], !iep[3] ? (w[11] | w[13]) : (cfg[7] ? 1'b0 : w[14]));
      chk(pinPortCOe, cfg[7] ? {3'b111, m, 2'b11} : {1'b1, w[25], 1'b1, m, 2'b00});
      chk(pinPortCOut[5], cfg[7] ? 1'b1 : w[22]);
      chk(pinPortCOut[4:3], cfg[7] ? 2'b01 : {w[24], w[23]});
      chk(pinPortCOut[1:0], cfg[7] ? 2'b10 : 2'b11);
      chk(chanAClearToSendN, cfg[7] ? 1'b1 : pat[1]);
      chk(chanACarrierDetectN, cfg[7] ? 1'b1 : pat[0]);
      chk(chanASyncIn, cfg[7] ? 1'b1 : pat[4]);
      chk(pinChipSelOut, iep[2] ? w[17] : w[16]);
      chk(async0ClearToSendN, cfg[5] ? 1'b0 : w[20]);
      chk(portBBit1In, cfg[5] ? w[20] : 1'b1);
    end
  endtask : check_pins

  ////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #200000;
    mismatches++;
    wrap_up;
  end

  initial begin
    logic [31:0] r;
    logic        e;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    pat = 8'h00;
    mismatches = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a += 4) begin
      apb(1'b0, 8'(a), 32'h0, r, e);
      chk(r, 32'h0);
    end
    apb(1'b1, ADDR_PORT_C_DATA, 32'h2A, r, e);
    apb(1'b1, ADDR_PORT_C_DIR, 32'h3F, r, e);
    apb(1'b0, ADDR_PORT_C_DATA, 32'h0, r, e);
    chk(r, 32'h2A);
    apb(1'b0, ADDR_PORT_C_DIR, 32'h0, r, e);
    chk(r, 32'h3F);
    foreach (cfgs[i]) begin
      foreach (ieps[j]) begin
        apb(1'b1, ADDR_SYS_CONFIG, {24'h0, cfgs[i]}, r, e);
        apb(1'b1, ADDR_INT_EDGE_PIN, {24'h0, ieps[j]}, r, e);
        check_pins(cfgs[i], ieps[j]);
      end
    end
    apb(1'b1, ADDR_PORT_C_LEVELS, 32'hFF, r, e);
    chk(e, 1'b0);
    pat <= 8'h55;
    apb(1'b0, ADDR_PORT_C_LEVELS, 32'h0, r, e);
    chk(r, {24'h0, w[19], w[18], pat[5:0]});
    apb(1'b0, 8'h14, 32'h0, r, e);
    chk(e, 1'b1);
    chk(r, 32'h0);
    wrap_up;
  end
endmodule : pin_function_mux_test
`default_nettype wire
